// >>> rtl/tsos_defines.svh
`ifndef TSOS_DEFINES_SVH
`define TSOS_DEFINES_SVH

// register addresses on the 6-bit register port
`define TSOS_ADDR_ANALOG 6'h3A
`define TSOS_ADDR_RSVD_A 6'h3B
`define TSOS_ADDR_RSVD_B 6'h3C
`define TSOS_ADDR_DIGITAL 6'h3D

// field positions
`define TSOS_ANA_MSB 3
`define TSOS_ANA_LSB 0
`define TSOS_OVR_BIT 7
`define TSOS_DIG_MSB 6
`define TSOS_DIG_LSB 0

// reset values
`define TSOS_ANA_RESET 8'h00
`define TSOS_DIG_RESET 8'h00

// digital probe codes as printed; only the low seven bits are compared
`define TSOS_CODE_SDATA 8'hF4
`define TSOS_CODE_SVALID 8'hE4
`define TSOS_CODE_SCOLL 8'hD4
`define TSOS_CODE_SCLOCK 8'hC4
`define TSOS_CODE_RDSYNC 8'hB5
`define TSOS_CODE_WRSYNC 8'hA5
`define TSOS_CODE_INTCLK 8'h96
`define TSOS_CODE_PKOUT 8'h83
`define TSOS_CODE_PKSIG 8'hE2

`endif

// >>> rtl/tsos_pkg.sv
package tsos_pkg;

    typedef enum logic [3:0] {
        TSOS_PROBE_SDATA = 4'h0,
        TSOS_PROBE_SVALID = 4'h1,
        TSOS_PROBE_SCOLL = 4'h2,
        TSOS_PROBE_SCLOCK = 4'h3,
        TSOS_PROBE_RDSYNC = 4'h4,
        TSOS_PROBE_WRSYNC = 4'h5,
        TSOS_PROBE_INTCLK = 4'h6,
        TSOS_PROBE_PKOUT = 4'h7,
        TSOS_PROBE_PKSIG = 4'h8,
        TSOS_PROBE_NONE = 4'hF
    } tsos_probe_t;

endpackage : tsos_pkg

// >>> rtl/tsos_probe_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsos_defines.svh"

module tsos_probe_mux
    import tsos_pkg::*;
(
    input wire logic [6:0] digital_probe_choice, // probe select field
    input wire logic [8:0] probe_signals, // internal digital probes, index per tsos_probe_t
    output logic probe_level // selected probe, low for unknown codes
);

    function automatic tsos_probe_t tsos_decode(input logic [6:0] code);
        case (code)
            7'(`TSOS_CODE_SDATA): tsos_decode = TSOS_PROBE_SDATA;
            7'(`TSOS_CODE_SVALID): tsos_decode = TSOS_PROBE_SVALID;
            7'(`TSOS_CODE_SCOLL): tsos_decode = TSOS_PROBE_SCOLL;
            7'(`TSOS_CODE_SCLOCK): tsos_decode = TSOS_PROBE_SCLOCK;
            7'(`TSOS_CODE_RDSYNC): tsos_decode = TSOS_PROBE_RDSYNC;
            7'(`TSOS_CODE_WRSYNC): tsos_decode = TSOS_PROBE_WRSYNC;
            7'(`TSOS_CODE_INTCLK): tsos_decode = TSOS_PROBE_INTCLK;
            7'(`TSOS_CODE_PKOUT): tsos_decode = TSOS_PROBE_PKOUT;
            7'(`TSOS_CODE_PKSIG): tsos_decode = TSOS_PROBE_PKSIG;
            default: tsos_decode = TSOS_PROBE_NONE;
        endcase
    endfunction : tsos_decode

    tsos_probe_t sel;

    always_comb begin
        sel = tsos_decode(digital_probe_choice);
        if (sel == TSOS_PROBE_NONE) begin
            probe_level = 1'b0;
        end else begin
            probe_level = probe_signals[sel];
        end
    end

endmodule : tsos_probe_mux

`default_nettype wire

// >>> rtl/tsos_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsos_defines.svh"

module tsos_top
    import tsos_pkg::*;
#(
    parameter int NORMAL_SOURCES = 8 // count of normal output sources
) (
    input wire logic sys_clk, // 125 MHz register clock
    input wire logic reset, // async, active high
    input wire logic reg_wr_en, // one-cycle write strobe
    input wire logic [5:0] reg_wr_addr, // register address
    input wire logic [7:0] reg_wr_data, // write data
    input wire logic [2:0] normal_output_source, // normal source selection field
    input wire logic [NORMAL_SOURCES-1:0] normal_sources, // normal source levels
    input wire logic [8:0] probe_signals, // internal digital probes
    output logic [3:0] analog_node_choice, // analog node routed to aux pin
    output logic multi_function_output_pin, // registered output pin level
    output logic probe_override_bit // override currently active
);

    // widths of the fields inside the two selector registers
    localparam int ANA_WIDTH = `TSOS_ANA_MSB - `TSOS_ANA_LSB + 1;
    localparam int DIG_WIDTH = `TSOS_DIG_MSB - `TSOS_DIG_LSB + 1;

    // write slot codes given by the address classifier
    localparam logic [1:0] SLOT_NONE = 2'h0;
    localparam logic [1:0] SLOT_ANALOG = 2'h1;
    localparam logic [1:0] SLOT_DIGITAL = 2'h2;

    // selector storage
    logic [7:0] analog_probe_select_reg;
    logic [7:0] digital_probe_select_reg;

    // write decode
    logic [1:0] wr_slot;
    logic hit_analog;
    logic hit_digital;

    // output path
    logic [ANA_WIDTH-1:0] analog_field;
    logic [DIG_WIDTH-1:0] probe_field;
    logic override_field;
    wire [NORMAL_SOURCES-1:0] normal_onehot;
    wire [NORMAL_SOURCES-1:0] normal_masked;
    logic probe_level;
    logic normal_level;
    logic [ANA_WIDTH-1:0] analog_node_next;
    logic override_next;
    logic multi_function_output_pin_next;

    // classifies a write address; reserved slots and unmapped addresses land nowhere
    function automatic logic [1:0] tsos_wr_slot(
        input logic [5:0] wr_addr
    );
        case (wr_addr)
            `TSOS_ADDR_ANALOG: begin
                tsos_wr_slot = SLOT_ANALOG;
            end
            `TSOS_ADDR_RSVD_A: begin
                tsos_wr_slot = SLOT_NONE;
            end
            `TSOS_ADDR_RSVD_B: begin
                tsos_wr_slot = SLOT_NONE;
            end
            `TSOS_ADDR_DIGITAL: begin
                tsos_wr_slot = SLOT_DIGITAL;
            end
            default: begin
                tsos_wr_slot = SLOT_NONE;
            end
        endcase
    endfunction : tsos_wr_slot

    // true when the strobe is up and the classified slot is the wanted one
    function automatic logic tsos_slot_hit(
        input logic wr_en,
        input logic [1:0] slot,
        input logic [1:0] target
    );
        tsos_slot_hit = wr_en && (slot == target);
    endfunction : tsos_slot_hit

    // aux code field of the analog selector
    function automatic logic [ANA_WIDTH-1:0] tsos_analog_field(
        input logic [7:0] value
    );
        tsos_analog_field = value[`TSOS_ANA_MSB:`TSOS_ANA_LSB];
    endfunction : tsos_analog_field

    // probe code field of the digital selector
    function automatic logic [DIG_WIDTH-1:0] tsos_probe_field(
        input logic [7:0] value
    );
        tsos_probe_field = value[`TSOS_DIG_MSB:`TSOS_DIG_LSB];
    endfunction : tsos_probe_field

    // override bit of the digital selector
    function automatic logic tsos_override_field(
        input logic [7:0] value
    );
        tsos_override_field = value[`TSOS_OVR_BIT];
    endfunction : tsos_override_field

    // address classification
    always_comb begin
        wr_slot = tsos_wr_slot(reg_wr_addr);
    end

    // the slot code only counts while the one-cycle strobe is up
    always_comb begin
        hit_analog = tsos_slot_hit(reg_wr_en, wr_slot, SLOT_ANALOG);
        hit_digital = tsos_slot_hit(reg_wr_en, wr_slot, SLOT_DIGITAL);
    end

    // upper four bits are stored as written and steer nothing
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            analog_probe_select_reg <= `TSOS_ANA_RESET;
        end else if (hit_analog) begin
            analog_probe_select_reg <= reg_wr_data;
        end
    end

    // undefined after reset in the device; held at zero so the pin starts normal
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            digital_probe_select_reg <= `TSOS_DIG_RESET;
        end else if (hit_digital) begin
            digital_probe_select_reg <= reg_wr_data;
        end
    end

    // aux field
    always_comb begin
        analog_field = tsos_analog_field(analog_probe_select_reg);
    end

    // probe select and override fields
    always_comb begin
        probe_field = tsos_probe_field(digital_probe_select_reg);
        override_field = tsos_override_field(digital_probe_select_reg);
    end

    // probe code decode and pick
    tsos_probe_mux u_probe_mux (
        .digital_probe_choice(probe_field),
        .probe_signals(probe_signals),
        .probe_level(probe_level)
    );

    // one-hot pick of the normal source; an index past the last source picks nothing
    for (genvar i = 0; i < NORMAL_SOURCES; i++) begin : g_normal
        assign normal_onehot[i] = (32'(normal_output_source) == i);
        assign normal_masked[i] = normal_onehot[i] & normal_sources[i];
    end

    // a picked source that is high drives the normal level
    always_comb begin
        if (|normal_masked) begin
            normal_level = 1'b1;
        end else begin
            normal_level = 1'b0;
        end
    end

    // the override bit alone decides which path reaches the pin
    always_comb begin
        if (override_field) begin
            multi_function_output_pin_next = probe_level;
        end else begin
            multi_function_output_pin_next = normal_level;
        end
    end

    // status values one register stage ahead of the outputs
    always_comb begin
        analog_node_next = analog_field;
        override_next = override_field;
    end

    // aux code output
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            analog_node_choice <= 4'h0;
        end else begin
            analog_node_choice <= analog_node_next;
        end
    end

    // selectors reach nothing but these observation outputs
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            multi_function_output_pin <= 1'b0;
        end else begin
            multi_function_output_pin <= multi_function_output_pin_next;
        end
    end

    // override status output
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            probe_override_bit <= 1'b0;
        end else begin
            probe_override_bit <= override_next;
        end
    end

endmodule : tsos_top

`default_nettype wire

// >>> tb/tsos_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tsos_checker #(parameter int NORMAL_SOURCES = 8) (
    input wire logic sys_clk, // clk
    input wire logic reset, // rst
    input wire logic reg_wr_en, // we
    input wire logic [5:0] reg_wr_addr, // addr
    input wire logic [7:0] reg_wr_data, // data
    input wire logic [2:0] normal_output_source, // sel
    input wire logic [NORMAL_SOURCES-1:0] normal_sources, // src
    input wire logic [8:0] probe_signals, // probes
    input wire logic [3:0] analog_node_choice, // aux
    input wire logic multi_function_output_pin, // pin
    input wire logic probe_override_bit // ovr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_a; reg_wr_en && reg_wr_addr == 6'h3A; endsequence
    sequence s_d; reg_wr_en && reg_wr_addr == 6'h3D; endsequence
    property p_rst; disable iff (1'b0) reset && $past(reset) |->
        analog_node_choice == 4'h0 && !probe_override_bit && !multi_function_output_pin; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_ana; s_a |-> ##2 analog_node_choice == $past(reg_wr_data[3:0], 2); endproperty
    a_ana: assert property (p_ana) else $error("analog code");
    property p_ovr; s_d |-> ##2 probe_override_bit == $past(reg_wr_data[7], 2); endproperty
    a_ovr: assert property (p_ovr) else $error("override");
    property p_sel; s_d and (reg_wr_data == 8'hF4) |->
        ##2 multi_function_output_pin == $past(probe_signals[0]); endproperty
    a_sel: assert property (p_sel) else $error("probe zero");
    property p_pko; s_d and (reg_wr_data == 8'h83) |->
        ##2 multi_function_output_pin == $past(probe_signals[7]); endproperty
    a_pko: assert property (p_pko) else $error("probe seven");
    property p_bad; s_d and (reg_wr_data == 8'hFF) |-> ##2 !multi_function_output_pin; endproperty
    a_bad: assert property (p_bad) else $error("unknown code");
    property p_norm; !$past(reset) && !probe_override_bit |->
        multi_function_output_pin == $past(normal_sources[normal_output_source]); endproperty
    a_norm: assert property (p_norm) else $error("normal source");
    property p_hold; !(reg_wr_en && reg_wr_addr inside {6'h3A, 6'h3D}) |->
        ##2 $stable(analog_node_choice) && $stable(probe_override_bit); endproperty
    a_hold: assert property (p_hold) else $error("selector moved");
endmodule : tsos_checker
bind tsos_top tsos_checker #(.NORMAL_SOURCES(NORMAL_SOURCES)) u_chk (
    .sys_clk(sys_clk),
    .reset(reset),
    .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data),
    .normal_output_source(normal_output_source),
    .normal_sources(normal_sources),
    .probe_signals(probe_signals),
    .analog_node_choice(analog_node_choice),
    .multi_function_output_pin(multi_function_output_pin),
    .probe_override_bit(probe_override_bit)
);
`default_nettype wire

// >>> tb/test_signal_output_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module test_signal_output_select_bench;
    logic sys_clk = 1'b0, reset = 1'b1, we = 1'b0;
    logic [5:0] wa = 6'h00;
    logic [7:0] wd = 8'h00, nv = 8'h00;
    logic [2:0] ns = 3'h0;
    logic [8:0] pr = 9'h000;
    wire logic [7:0] obs;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    assign obs[5:4] = 2'h0;
    tsos_top uut (.sys_clk(sys_clk), .reset(reset), .reg_wr_en(we), .reg_wr_addr(wa), .reg_wr_data(wd),
        .normal_output_source(ns), .normal_sources(nv), .probe_signals(pr),
        .analog_node_choice(obs[3:0]), .multi_function_output_pin(obs[6]),
        .probe_override_bit(obs[7]));
    initial forever #4 sys_clk = ~sys_clk;
    task automatic chk(logic [7:0] g, logic [7:0] e);
        cmp_count++;
        if (g !== e) fail_count++;
        if (g !== e) $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    endtask : chk
    task automatic op(logic w, logic [5:0] a, logic [7:0] d, logic [8:0] p, logic [10:0] sv);
        @(posedge sys_clk) {we, wa, wd, pr, ns, nv} <= {w, a, d, p, sv};
        @(posedge sys_clk) we <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : op
    task automatic t_regs;
        chk(obs, 8'h00);
        for (int c = 0; c < 16; c++) begin
            op(1'b1, 6'h3A, 8'(c), 9'h000, 11'h000);
            chk(obs, 8'(c));
        end
        for (int r = 0; r < 2; r++) op(1'b1, 6'h3B + 6'(r), 8'h80, 9'h000, 11'h000);
        chk(obs, 8'h0F);
    endtask : t_regs
    task automatic t_dig;
        logic [7:0] code [9] = '{8'hF4, 8'hE4, 8'hD4, 8'hC4, 8'hB5, 8'hA5, 8'h96, 8'h83, 8'hE2};
        for (int i = 0; i < 9; i++) begin
            op(1'b1, 6'h3D, code[i], 9'h001 << i, 11'h0FF);
            chk(obs, 8'hCF);
            op(1'b0, 6'h00, 8'h00, ~(9'h001 << i), 11'h0FF);
            chk(obs, 8'h8F);
        end
        op(1'b1, 6'h3D, 8'hFF, 9'h1FF, 11'h000);
        chk(obs, 8'h8F);
    endtask : t_dig
    task automatic t_norm;
        for (int s = 0; s < 8; s++) begin
            op(1'b1, 6'h3D, 8'h74, 9'h1FF, {3'(s), 8'h01 << s});
            chk(obs, 8'h4F);
        end
    endtask : t_norm
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) fail_count++;
        if (cyc == 2000) final_report();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        t_regs();
        t_dig();
        t_norm();
        final_report();
    end
endmodule : test_signal_output_select_bench
`default_nettype wire
